// File: include/arl_defines.svh
`ifndef ARL_DEFINES_SVH
`define ARL_DEFINES_SVH

// Word width of accumulator and all register spaces
`define ARL_WIDTH      16
// Status bit positions written by compare commands
`define ARL_LT_BIT     1
`define ARL_EQ_BIT     2
`define ARL_GT_BIT     3
// Bit of the edge-history temporary register holding the last 1-bit value
`define ARL_PREV_BIT   0
// Reset values
`define ARL_ACC_RST    16'h0000
`define ARL_WORD_RST   16'h0000

`endif

// File: include/arl_pkg.sv
package arl_pkg;

    typedef enum logic [2:0] {
        ARL_F_LOAD    = 3'b000,
        ARL_F_COMPARE = 3'b001,
        ARL_F_AND     = 3'b010,
        ARL_F_OR      = 3'b011,
        ARL_F_XOR     = 3'b100,
        ARL_F_STORE   = 3'b101
    } arl_func_t;

    typedef enum logic [1:0] {
        ARL_S_CONST   = 2'b00,
        ARL_S_GENERAL = 2'b01,
        ARL_S_TEMP    = 2'b10,
        ARL_S_NONVOL  = 2'b11
    } arl_src_t;

endpackage

// File: rtl/arl_core.sv
`timescale 1ns/1ns
`include "arl_defines.svh"
// Summary of operation
// RL1: All register commands act on a 16-bit accumulator with unsigned operands.
// RL2: Loading a constant replaces the accumulator with the immediate value.
// RL3: Register loads copy a general, temporary or non-volatile word in.
// RL4: Constant compare writes less, equal, greater to bits 1, 2, 3 of a temp.
// RL5: Register compare sets the same three bits from a word of any space.
// RL6: A compare sets exactly one of the three status bits and clears the rest.
// RL7: Constant AND leaves immediate AND accumulator in the accumulator.
// RL8: Register AND leaves the word AND accumulator in the accumulator.
// RL9: Constant OR leaves immediate OR accumulator in the accumulator.
// RL10: Register OR of general or temporary words ORs into the accumulator.
// RL11: The non-volatile OR command performs an exclusive OR instead.
// RL12: Exclusive OR with an immediate or any space leaves the result in acc.
// RL13: Edge stores write the accumulator only on a rising 1-bit accumulator.
// RL14: The edge store keeps the last 1-bit value in its temporary argument.
// RL15: The 1-bit accumulator comes from the separate bit command logic.
module arl_core #(
    parameter int AW = 8
) (
    input  wire logic                    REF_CLK,
    input  wire logic                    RST,
    input  wire logic                    CMD_VALID,
    input  wire arl_pkg::arl_func_t      CMD_FUNC,
    input  wire arl_pkg::arl_src_t       CMD_SRC,
    input  wire logic [`ARL_WIDTH-1:0]   CMD_ARG1,
    input  wire logic [AW-1:0]           CMD_ARG2,
    input  wire logic                    BIT_ACC,
    input  wire arl_pkg::arl_src_t       RD_SRC,
    input  wire logic [AW-1:0]           RD_ADDR,
    output logic      [`ARL_WIDTH-1:0]   ACC,
    output logic                         CMD_DONE,
    output logic                         STORE_FIRED,
    output logic      [`ARL_WIDTH-1:0]   RD_DATA
);
    import arl_pkg::*;

    localparam int DEPTH = 2 ** AW;

    logic [`ARL_WIDTH-1:0] gen_mem [DEPTH];
    logic [`ARL_WIDTH-1:0] tmp_mem [DEPTH];
    logic [`ARL_WIDTH-1:0] nv_mem  [DEPTH];

    logic [`ARL_WIDTH-1:0] acc_q,   acc_d;
    logic                  done_q,  done_d;
    logic                  fired_q, fired_d;
    logic [`ARL_WIDTH-1:0] rd_q,    rd_d;

    // Addresses: first argument names the word, second the temp status
    logic [AW-1:0]         word_addr;
    logic [AW-1:0]         hist_addr;

    // Datapath terms
    logic [`ARL_WIDTH-1:0] operand;
    logic                  cmp_lt;
    logic                  cmp_eq;
    logic                  cmp_gt;
    logic [`ARL_WIDTH-1:0] status;
    logic [`ARL_WIDTH-1:0] hist_word;
    logic [`ARL_WIDTH-1:0] hist_next;
    logic                  prev_bit;
    logic                  rise;

    // Store target space, decoded from the source field
    logic                  tgt_gen;
    logic                  tgt_tmp;
    logic                  tgt_nv;

    // Decoded command strobes, each do_ strobe qualified by CMD_VALID; or_is_xor is decoded from the source field alone
    logic                  do_load;
    logic                  do_compare;
    logic                  do_and;
    logic                  do_or;
    logic                  do_xor;
    logic                  do_store;
    logic                  or_is_xor;

    // Write ports; temp port B is applied last so it wins a shared address
    logic                  gen_we;
    logic                  nv_we;
    logic                  tmpa_we;
    logic                  tmpb_we;
    logic [`ARL_WIDTH-1:0] tmpa_data;

    ////////////////////////////////////////////////////////////////////////
    // Address split; upper bits of the first argument are ignored
    always_comb begin
        word_addr = CMD_ARG1[AW-1:0];
        hist_addr = CMD_ARG2;
    end

    ////////////////////////////////////////////////////////////////////////
    // Operand select; a constant is taken as the immediate itself
    always_comb begin
        case (CMD_SRC)
            ARL_S_CONST:   operand = CMD_ARG1; // RL2
            ARL_S_GENERAL: operand = gen_mem[word_addr]; // RL3
            ARL_S_TEMP:    operand = tmp_mem[word_addr]; // RL3
            ARL_S_NONVOL:  operand = nv_mem[word_addr]; // RL3
            default:       operand = CMD_ARG1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Unsigned magnitude compare of the accumulator against the operand
    always_comb begin
        cmp_lt = acc_q < operand; // RL1 RL4 RL5
        cmp_eq = acc_q == operand; // RL4 RL5
        cmp_gt = acc_q > operand; // RL4 RL5
    end

    ////////////////////////////////////////////////////////////////////////
    // Exactly one result bit is set; the word's other bits are kept, so the
    // program may share one temp word between status and its own flags
    always_comb begin
        status = tmp_mem[hist_addr];
        status[`ARL_LT_BIT] = cmp_lt; // RL6
        status[`ARL_EQ_BIT] = cmp_eq; // RL6
        status[`ARL_GT_BIT] = cmp_gt; // RL6
    end

    ////////////////////////////////////////////////////////////////////////
    // Edge history lives in bit 0 of the second argument's temp word
    always_comb begin
        hist_word = tmp_mem[hist_addr];
        prev_bit  = hist_word[`ARL_PREV_BIT];
        rise      = !prev_bit && BIT_ACC; // RL14 RL15
        hist_next = hist_word;
        hist_next[`ARL_PREV_BIT] = BIT_ACC; // RL14
    end

    ////////////////////////////////////////////////////////////////////////
    // Store target space, from the same source field as the operand
    always_comb begin
        tgt_gen = (CMD_SRC == ARL_S_GENERAL);
        tgt_tmp = (CMD_SRC == ARL_S_TEMP);
        tgt_nv  = (CMD_SRC == ARL_S_NONVOL);
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode; encodings six and seven fall through as no-ops.
    // Nothing stalls: every command finishes in the edge that takes it.
    always_comb begin
        do_load    = 1'h0;
        do_compare = 1'h0;
        do_and     = 1'h0;
        do_or      = 1'h0;
        do_xor     = 1'h0;
        do_store   = 1'h0;
        or_is_xor  = tgt_nv;
        if (CMD_VALID) begin
            case (CMD_FUNC)
                ARL_F_LOAD: begin
                    do_load = 1'h1;
                end
                ARL_F_COMPARE: begin
                    do_compare = 1'h1;
                end
                ARL_F_AND: begin
                    do_and = 1'h1;
                end
                ARL_F_OR: begin
                    do_or = 1'h1;
                end
                ARL_F_XOR: begin
                    do_xor = 1'h1;
                end
                ARL_F_STORE: begin
                    // A constant names no register, so the store is refused
                    do_store = (CMD_SRC != ARL_S_CONST);
                end
                default: begin
                    do_load = 1'h0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator; commands that do not name it leave it alone
    always_comb begin
        acc_d = acc_q;
        if (do_load) begin
            acc_d = operand; // RL2 RL3
        end else if (do_and) begin
            acc_d = acc_q & operand; // RL7 RL8
        end else if (do_or) begin
            // Non-volatile OR acts as exclusive OR; programs must expect it
            if (or_is_xor) begin
                acc_d = acc_q ^ operand; // RL11
            end else begin
                acc_d = acc_q | operand; // RL9 RL10
            end
        end else if (do_xor) begin
            acc_d = acc_q ^ operand; // RL12
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            acc_q <= `ARL_ACC_RST;
        end else begin
            acc_q <= acc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion pulses; done follows refused stores and no-ops too
    always_comb begin
        done_d  = CMD_VALID;
        fired_d = do_store && rise; // RL13
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            done_q  <= 1'h0;
            fired_q <= 1'h0;
        end else begin
            done_q  <= done_d;
            fired_q <= fired_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes; history is rewritten on every register-target store
    always_comb begin
        gen_we    = do_store && rise && tgt_gen; // RL13
        nv_we     = do_store && rise && tgt_nv; // RL13
        tmpb_we   = do_store && rise && tgt_tmp; // RL13
        tmpa_we   = do_compare || do_store; // RL4 RL5 RL14
        tmpa_data = status;
        if (do_store) begin
            tmpa_data = hist_next; // RL14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General space
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                gen_mem[i] <= `ARL_WORD_RST;
            end
        end else if (gen_we) begin
            gen_mem[word_addr] <= acc_q; // RL13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Non-volatile space is plain registers cleared by reset; retention
    // across power loss is outside this block
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                nv_mem[i] <= `ARL_WORD_RST;
            end
        end else if (nv_we) begin
            nv_mem[word_addr] <= acc_q; // RL13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Temporary space: status or history through port A, store through
    // port B. When a store names its own history word as target, the
    // stored accumulator wins and the history bit is lost; the program
    // should keep the two apart.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < DEPTH; i++) begin
                tmp_mem[i] <= `ARL_WORD_RST;
            end
        end else begin
            if (tmpa_we) begin
                tmp_mem[hist_addr] <= tmpa_data;
            end
            if (tmpb_we) begin
                tmp_mem[word_addr] <= acc_q; // RL13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Observation port shows contents before this edge's writes
    always_comb begin
        case (RD_SRC)
            ARL_S_GENERAL: rd_d = gen_mem[RD_ADDR];
            ARL_S_TEMP:    rd_d = tmp_mem[RD_ADDR];
            ARL_S_NONVOL:  rd_d = nv_mem[RD_ADDR];
            default:       rd_d = `ARL_WORD_RST;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rd_q <= `ARL_WORD_RST;
        end else begin
            rd_q <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Every output leaves straight from its register
    assign ACC         = acc_q;
    assign CMD_DONE    = done_q;
    assign STORE_FIRED = fired_q;
    assign RD_DATA     = rd_q;

endmodule

// File: testbench/arl_prog.sv
`timescale 1ns/1ns
module arl_prog (
    input  wire logic                clk,
    output logic                     valid = 1'b0,
    output arl_pkg::arl_func_t       func = arl_pkg::ARL_F_LOAD,
    output arl_pkg::arl_src_t        src = arl_pkg::ARL_S_CONST,
    output logic              [15:0] arg1 = 16'h0000,
    output logic              [3:0]  arg2 = 4'h0,
    output logic                     bit_acc = 1'b0
);
    import arl_pkg::*;
    // Idle arg1 and arg2 inverted so a stale operand is never mistaken for live
    task automatic issue(arl_func_t f, arl_src_t s, logic [15:0] x,
                         logic [3:0] y, logic b);
        @(posedge clk) #1;
        valid = 1'b1;
        func = f;
        src = s;
        arg1 = x;
        arg2 = y;
        bit_acc = b;
        @(posedge clk) #1;
        valid = 1'b0;
        arg1 = ~arg1;
        arg2 = ~arg2;
    endtask
endmodule

// File: testbench/arl_core_asserts.sv
`timescale 1ns/1ns
module arl_core_asserts (
    input wire logic                REF_CLK,
    input wire logic                RST,
    input wire logic                CMD_VALID,
    input wire arl_pkg::arl_func_t  CMD_FUNC,
    input wire arl_pkg::arl_src_t   CMD_SRC,
    input wire logic         [15:0] CMD_ARG1,
    input wire logic                BIT_ACC,
    input wire logic         [15:0] ACC,
    input wire logic                CMD_DONE,
    input wire logic                STORE_FIRED
);
    import arl_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    sequence s_k(arl_func_t f);
        CMD_VALID && CMD_FUNC == f && CMD_SRC == ARL_S_CONST;
    endsequence
    chk_load_const: assert property (
        s_k(ARL_F_LOAD) |=> ACC == $past(CMD_ARG1)) else $error("bad load");
    chk_and_const: assert property (
        s_k(ARL_F_AND) |=> ACC == ($past(ACC) & $past(CMD_ARG1)))
        else $error("bad and");
    chk_or_const: assert property (
        s_k(ARL_F_OR) |=> ACC == ($past(ACC) | $past(CMD_ARG1)))
        else $error("bad or");
    chk_xor_const: assert property (
        s_k(ARL_F_XOR) |=> ACC == ($past(ACC) ^ $past(CMD_ARG1)))
        else $error("bad xor");
    chk_cmp_keeps: assert property (
        s_k(ARL_F_COMPARE) |=> $stable(ACC)) else $error("compare moved acc");
    chk_no_edge: assert property (
        CMD_VALID && CMD_FUNC == ARL_F_STORE && !BIT_ACC |=> !STORE_FIRED)
        else $error("store without edge");
    chk_fire_cause: assert property (
        STORE_FIRED |-> $past(CMD_VALID && CMD_FUNC == ARL_F_STORE &&
        BIT_ACC && CMD_SRC != ARL_S_CONST))
        else $error("store fired without cause");
    chk_done_pulse: assert property (
        CMD_VALID |=> CMD_DONE) else $error("command not completed");
    chk_const_store: assert property (
        s_k(ARL_F_STORE) |=> !STORE_FIRED && $stable(ACC))
        else $error("constant store acted");
    chk_idle_hold: assert property (
        !CMD_VALID |=> $stable(ACC) && !CMD_DONE) else $error("idle change");
endmodule
bind arl_core arl_core_asserts u_arl_core_asserts (.REF_CLK(REF_CLK),
    .RST(RST), .CMD_VALID(CMD_VALID), .CMD_FUNC(CMD_FUNC),
    .CMD_SRC(CMD_SRC), .CMD_ARG1(CMD_ARG1), .BIT_ACC(BIT_ACC), .ACC(ACC),
    .CMD_DONE(CMD_DONE), .STORE_FIRED(STORE_FIRED));

// File: testbench/tb_arl_core.sv
`timescale 1ns/1ns
module tb_arl_core;
    import arl_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, v, b, done, fired;
    arl_func_t   f;
    arl_src_t    s, rs = ARL_S_CONST;
    logic [15:0] a1, acc, rd;
    logic [3:0]  a2, ra = 4'h0;
    int          fail_count = 0, checks = 0, cyc = 0;
    arl_prog u_arl_prog (.clk(ref_clk), .valid(v), .func(f), .src(s),
        .arg1(a1), .arg2(a2), .bit_acc(b));
    arl_core #(.AW(4)) u_arl_core (.REF_CLK(ref_clk), .RST(rst),
        .CMD_VALID(v), .CMD_FUNC(f), .CMD_SRC(s), .CMD_ARG1(a1),
        .CMD_ARG2(a2), .BIT_ACC(b), .RD_SRC(rs), .RD_ADDR(ra), .ACC(acc),
        .CMD_DONE(done), .STORE_FIRED(fired), .RD_DATA(rd));
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc > 2000) begin
        fail_count++;
        finish_test();
    end
    task chk(string n, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task op(arl_func_t fn, arl_src_t sr, logic [15:0] x, logic [3:0] y,
            logic bt);
        u_arl_prog.issue(fn, sr, x, y, bt);
    endtask
    task rdc(arl_src_t sp, logic [3:0] ad, logic [15:0] exp);
        @(posedge ref_clk) #1;
        rs = sp;
        ra = ad;
        @(posedge ref_clk) #1;
        chk("word", rd, exp);
    endtask
    task t_logic();
        op(ARL_F_LOAD, ARL_S_CONST, 16'hffff, 4'h0, 1'b0);
        chk("acc", acc, 16'hffff);
        chk("done", done, 1'b1);
        op(ARL_F_AND, ARL_S_CONST, 16'h0ff0, 4'h0, 1'b0);
        chk("acc", acc, 16'h0ff0);
        op(ARL_F_OR, ARL_S_CONST, 16'h8001, 4'h0, 1'b0);
        chk("acc", acc, 16'h8ff1);
        op(ARL_F_XOR, ARL_S_CONST, 16'hffff, 4'h0, 1'b0);
        chk("acc", acc, 16'h700e);
    endtask
    task t_store();
        op(ARL_F_STORE, ARL_S_GENERAL, 16'h0003, 4'h1, 1'b1);
        chk("fired", fired, 1'b1);
        op(ARL_F_LOAD, ARL_S_CONST, 16'h1234, 4'h0, 1'b0);
        op(ARL_F_STORE, ARL_S_GENERAL, 16'h0003, 4'h1, 1'b1);
        chk("fired", fired, 1'b0);
        op(ARL_F_STORE, ARL_S_TEMP, 16'h0005, 4'h2, 1'b1);
        op(ARL_F_STORE, ARL_S_NONVOL, 16'h0007, 4'h6, 1'b1);
        op(ARL_F_STORE, ARL_S_NONVOL, 16'h0009, 4'h9, 1'b0);
        op(ARL_F_STORE, ARL_S_CONST, 16'h0004, 4'h4, 1'b1);
        chk("fired", fired, 1'b0);
        chk("done", done, 1'b1);
        rdc(ARL_S_TEMP, 4'h4, 16'h0000);
        rdc(ARL_S_GENERAL, 4'h3, 16'h700e);
        rdc(ARL_S_TEMP, 4'h5, 16'h1234);
        rdc(ARL_S_NONVOL, 4'h7, 16'h1234);
        rdc(ARL_S_NONVOL, 4'h9, 16'h0000);
        rdc(ARL_S_TEMP, 4'h1, 16'h0001);
    endtask
    task t_ops();
        op(ARL_F_LOAD, ARL_S_GENERAL, 16'h0003, 4'h0, 1'b0);
        chk("acc", acc, 16'h700e);
        op(ARL_F_AND, ARL_S_TEMP, 16'h0005, 4'h0, 1'b0);
        chk("acc", acc, 16'h1004);
        op(ARL_F_OR, ARL_S_GENERAL, 16'h0003, 4'h0, 1'b0);
        chk("acc", acc, 16'h700e);
        op(ARL_F_OR, ARL_S_NONVOL, 16'h0007, 4'h0, 1'b0);
        chk("acc", acc, 16'h623a);
        op(ARL_F_XOR, ARL_S_TEMP, 16'h0005, 4'h0, 1'b0);
        chk("acc", acc, 16'h700e);
        op(ARL_F_LOAD, ARL_S_NONVOL, 16'h0007, 4'h0, 1'b0);
        chk("acc", acc, 16'h1234);
    endtask
    task t_cmp();
        op(ARL_F_COMPARE, ARL_S_CONST, 16'h1235, 4'ha, 1'b0);
        rdc(ARL_S_TEMP, 4'ha, 16'h0002);
        op(ARL_F_COMPARE, ARL_S_CONST, 16'h1233, 4'ha, 1'b0);
        rdc(ARL_S_TEMP, 4'ha, 16'h0008);
        op(ARL_F_COMPARE, ARL_S_NONVOL, 16'h0007, 4'ha, 1'b0);
        rdc(ARL_S_TEMP, 4'ha, 16'h0004);
    endtask
    task finish_test();
        $display("checks %0d, fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        #1 rst = 1'b0;
        t_logic();
        t_store();
        t_ops();
        t_cmp();
        finish_test();
    end
endmodule
